// ### logic/cpr_map.svh
`ifndef CPR_MAP_SVH
`define CPR_MAP_SVH

// bank address selecting a mode register on a mode register set
`define CPR_BA_MR0 3'h0
`define CPR_BA_MR3 3'h3
// mode_register_three fields
`define CPR_MR3_EN 2
`define CPR_MR3_LOC_HI 1
`define CPR_MR3_LOC_LO 0
// mode_register_zero burst length field and its codes
`define CPR_MR0_BL_HI 1
`define CPR_MR0_BL_LO 0
`define CPR_BL_FIX8 2'h0
`define CPR_BL_OTF 2'h1
`define CPR_BL_FIX4 2'h2
// address lines of a read command
`define CPR_A_NIB 2
`define CPR_A_AP 10
`define CPR_A_BC 12
// burst beats
`define CPR_BEAT_FIRST 3'h0
`define CPR_BEAT_HALF 3'h4
`define CPR_BEAT_MID 3'h3
`define CPR_BEAT_LAST 3'h7
// pattern contents, beat 0 in bit 0
`define CPR_PAT_LOC0 8'hAA
`define CPR_PAT_RSVD 8'h00
`define CPR_LOC_CAL 2'h0
// register offsets
`define CPR_OFS_CTRL 4'h0
`define CPR_OFS_STAT 4'h4
`define CPR_OFS_CNT 4'h8
// control register fields and reset value
`define CPR_CTRL_COPY 0
`define CPR_CTRL_WIDE 1
`define CPR_CTRL_RL_HI 7
`define CPR_CTRL_RL_LO 4
`define CPR_CTRL_RST 8'h51
// bus responses
`define CPR_RESP_OKAY 2'h0
`define CPR_RESP_DECERR 2'h3

`endif

// ### logic/cpr_pkg.sv
package cpr_pkg;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_MRS = 3'h1,
    CMD_READ = 3'h2,
    CMD_WRITE = 3'h3,
    CMD_OTHER = 3'h4
  } cpr_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_BURST = 2'h3
  } cpr_state_t;

endpackage : cpr_pkg

// ### logic/cpr_pattern_rom.sv
`timescale 1ns/100ps
`include "cpr_map.svh"

module cpr_pattern_rom (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] loc,
  output logic [7:0] pat
);

  logic [7:0] pat_r;
  logic [7:0] pat_nxt;

  always_comb begin
    case (loc)
      `CPR_LOC_CAL: pat_nxt = `CPR_PAT_LOC0;
      default: pat_nxt = `CPR_PAT_RSVD;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pat_r <= `CPR_PAT_RSVD;
    end else begin
      pat_r <= pat_nxt;
    end
  end

  assign pat = pat_r;

endmodule : cpr_pattern_rom

// ### logic/cpr_readout.sv
// What this block does and what its controller must do
// R1: mode register set to register three with A2 high enters pattern mode.
// R2: controller idles and precharges all banks before enabling pattern mode.
// R3: in pattern mode every read is served from the pattern register.
// R4: register three bits one and zero pick the pattern location.
// R5: controller issues only reads until register three A2 returns to zero.
// R6: read with auto precharge acts as a plain read, no precharge.
// R7: no power-down, self-refresh or non-read command in pattern mode.
// R8: asynchronous reset still works while pattern mode is on.
// R9: enable bit zero ignores location and sends accesses to the array.
// R10: eight-bit part puts pattern on line zero, others copy or zero.
// R11: sixteen-bit part puts pattern on bit zero of both lanes.
// R12: pattern reads ignore bank bits and column bits nine to three.
// R13: controller drives column bits one and zero as zero.
// R14: eight-beat pattern bursts come out in fixed order zero to seven.
// R15: burst chop gives beats zero-three for A2 low, four-seven high.
// R16: A12 picks burst chop on the fly when register zero allows.
// R17: pattern reads use the same latency and timing as array reads.
// R18: controller waits for the delay-locked loop before pattern reads.
// R19: beat zero is the pattern's lowest bit, beat seven its highest.
// R20: location zero returns alternating zero and one on each beat.
// R21: controller uses only location zero, others are reserved.
// R22: controller selects register three with BA1 and BA0 high, BA2 low.
`timescale 1ns/100ps
`include "cpr_map.svh"

module cpr_readout #(
  parameter int ADDR_W = 16
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CMD_CS_N,
  input wire logic CMD_RAS_N,
  input wire logic CMD_CAS_N,
  input wire logic CMD_WE_N,
  input wire logic [2:0] CMD_BA,
  input wire logic [ADDR_W-1:0] CMD_ADDR,
  input wire logic [15:0] ARRAY_RDATA,
  output logic ARRAY_RD_REQ,
  output logic ARRAY_WR_REQ,
  output logic ARRAY_AP,
  output logic [2:0] ARRAY_BA,
  output logic [ADDR_W-1:0] ARRAY_ADDR,
  output logic [15:0] DQ_OUT,
  output logic [1:0] DQ_OE,
  input wire logic AXI_AWVALID,
  output logic AXI_AWREADY,
  input wire logic [3:0] AXI_AWADDR,
  input wire logic AXI_WVALID,
  output logic AXI_WREADY,
  input wire logic [31:0] AXI_WDATA,
  input wire logic [3:0] AXI_WSTRB,
  output logic AXI_BVALID,
  input wire logic AXI_BREADY,
  output logic [1:0] AXI_BRESP,
  input wire logic AXI_ARVALID,
  output logic AXI_ARREADY,
  input wire logic [3:0] AXI_ARADDR,
  output logic AXI_RVALID,
  input wire logic AXI_RREADY,
  output logic [31:0] AXI_RDATA,
  output logic [1:0] AXI_RRESP
);

  initial begin
    if (ADDR_W < 13 || ADDR_W > 16) begin
      $error("ADDR_W must lie between 13 and 16");
    end
  end

  function automatic cpr_pkg::cpr_cmd_t decode(input logic cs_n,
      input logic ras_n, input logic cas_n, input logic we_n);
    if (cs_n) begin
      decode = cpr_pkg::CMD_NOP;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'h0: decode = cpr_pkg::CMD_MRS;
        3'h5: decode = cpr_pkg::CMD_READ;
        3'h4: decode = cpr_pkg::CMD_WRITE;
        3'h7: decode = cpr_pkg::CMD_NOP;
        default: decode = cpr_pkg::CMD_OTHER;
      endcase
    end
  endfunction : decode

  function automatic logic is_chop(input logic [1:0] bl, input logic a12);
    is_chop = (bl == `CPR_BL_FIX4) || ((bl == `CPR_BL_OTF) && !a12);
  endfunction : is_chop

  cpr_pkg::cpr_cmd_t cmd;
  logic chop;
  logic [7:0] pat;

  // mode registers
  logic pmode_r, pmode_nxt;
  logic [1:0] loc_r, loc_nxt;
  logic [1:0] bl_r, bl_nxt;

  // burst engine
  cpr_pkg::cpr_state_t state_r, state_nxt;
  logic [3:0] lat_r, lat_nxt;
  logic [2:0] beat_r, beat_nxt;
  logic [2:0] end_r, end_nxt;
  logic src_pat_r, src_pat_nxt;
  logic [15:0] cnt_r, cnt_nxt;

  // command outputs and data outputs
  logic rd_req_r, rd_req_nxt, wr_req_r, wr_req_nxt, ap_r, ap_nxt;
  logic [2:0] ba_r, ba_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [15:0] dq_r, dq_nxt;
  logic [1:0] oe_r, oe_nxt;
  logic dq_pat_r, dq_pat_nxt;
  logic [2:0] dq_beat_r, dq_beat_nxt;

  // register bus
  logic [7:0] ctrl_r, ctrl_nxt;
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [3:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  assign cmd = decode(CMD_CS_N, CMD_RAS_N, CMD_CAS_N, CMD_WE_N);
  // R16 chop on the fly
  assign chop = is_chop(bl_r, CMD_ADDR[`CPR_A_BC]);

  cpr_pattern_rom u_rom (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .loc(loc_r),
    .pat(pat)
  );

  always_comb begin
    pmode_nxt = pmode_r;
    loc_nxt = loc_r;
    bl_nxt = bl_r;
    if (cmd == cpr_pkg::CMD_MRS && CMD_BA == `CPR_BA_MR3) begin
      // R1 enable bit sets mode
      pmode_nxt = CMD_ADDR[`CPR_MR3_EN];
      // R4 location field
      loc_nxt = CMD_ADDR[`CPR_MR3_LOC_HI:`CPR_MR3_LOC_LO];
    end
    if (cmd == cpr_pkg::CMD_MRS && CMD_BA == `CPR_BA_MR0) begin
      bl_nxt = CMD_ADDR[`CPR_MR0_BL_HI:`CPR_MR0_BL_LO];
    end
  end

  always_comb begin
    state_nxt = state_r;
    lat_nxt = lat_r;
    beat_nxt = beat_r;
    end_nxt = end_r;
    src_pat_nxt = src_pat_r;
    cnt_nxt = cnt_r;
    rd_req_nxt = 1'b0;
    wr_req_nxt = 1'b0;
    ap_nxt = 1'b0;
    ba_nxt = ba_r;
    addr_nxt = addr_r;
    case (state_r)
      cpr_pkg::ST_IDLE: begin
        if (cmd == cpr_pkg::CMD_READ) begin
          state_nxt = cpr_pkg::ST_WAIT;
          // R17 same latency for both sources
          lat_nxt = ctrl_r[`CPR_CTRL_RL_HI:`CPR_CTRL_RL_LO];
          // R3 redirect reads to the pattern
          src_pat_nxt = pmode_r;
          // R14 R15 burst order by chop and A2
          if (chop && CMD_ADDR[`CPR_A_NIB]) begin
            beat_nxt = `CPR_BEAT_HALF;
            end_nxt = `CPR_BEAT_LAST;
          end else begin
            beat_nxt = `CPR_BEAT_FIRST;
            end_nxt = chop ? `CPR_BEAT_MID : `CPR_BEAT_LAST;
          end
          if (pmode_r) begin
            // R6 R12 address and precharge ignored
            cnt_nxt = cnt_r + 16'h1;
          end else begin
            // R9 normal array read
            rd_req_nxt = 1'b1;
            ap_nxt = CMD_ADDR[`CPR_A_AP];
            ba_nxt = CMD_BA;
            addr_nxt = CMD_ADDR;
          end
        end
      end
      cpr_pkg::ST_WAIT: begin
        lat_nxt = lat_r - 4'h1;
        if (lat_r <= 4'h1) begin
          state_nxt = cpr_pkg::ST_BURST;
        end
      end
      cpr_pkg::ST_BURST: begin
        if (beat_r == end_r) begin
          state_nxt = cpr_pkg::ST_IDLE;
        end else begin
          beat_nxt = beat_r + 3'h1;
        end
      end
      default: state_nxt = cpr_pkg::ST_IDLE;
    endcase
    // R9 writes reach the array only in normal mode
    if (cmd == cpr_pkg::CMD_WRITE && !pmode_r) begin
      wr_req_nxt = 1'b1;
      ap_nxt = CMD_ADDR[`CPR_A_AP];
      ba_nxt = CMD_BA;
      addr_nxt = CMD_ADDR;
    end
  end

  always_comb begin
    dq_nxt = 16'h0000;
    oe_nxt = 2'h0;
    dq_pat_nxt = 1'b0;
    dq_beat_nxt = beat_r;
    if (state_r == cpr_pkg::ST_BURST) begin
      dq_pat_nxt = src_pat_r;
      if (src_pat_r) begin
        // R19 R20 beat selects pattern bit
        // R10 line zero carries it, others copy or zero
        dq_nxt[7:0] = ctrl_r[`CPR_CTRL_COPY] ? {8{pat[beat_r]}}
                                              : {7'h00, pat[beat_r]};
        // R11 upper lane mirrors lower lane
        if (ctrl_r[`CPR_CTRL_WIDE]) begin
          dq_nxt[15:8] = dq_nxt[7:0];
        end
      end else begin
        dq_nxt = ARRAY_RDATA;
        if (!ctrl_r[`CPR_CTRL_WIDE]) begin
          dq_nxt[15:8] = 8'h00;
        end
      end
      oe_nxt = {ctrl_r[`CPR_CTRL_WIDE], 1'b1};
    end
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    aw_have_nxt = aw_have_r | (AXI_AWVALID & awready_r);
    aw_addr_nxt = (AXI_AWVALID & awready_r) ? AXI_AWADDR : aw_addr_r;
    w_have_nxt = w_have_r | (AXI_WVALID & wready_r);
    w_data_nxt = (AXI_WVALID & wready_r) ? AXI_WDATA : w_data_r;
    w_strb_nxt = (AXI_WVALID & wready_r) ? AXI_WSTRB : w_strb_r;
    bvalid_nxt = bvalid_r & ~AXI_BREADY;
    bresp_nxt = bresp_r;
    if (aw_have_nxt && w_have_nxt && !bvalid_r) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `CPR_RESP_OKAY;
      case (aw_addr_nxt)
        `CPR_OFS_CTRL: begin
          if (w_strb_nxt[0]) begin
            ctrl_nxt = w_data_nxt[7:0];
          end
        end
        `CPR_OFS_STAT, `CPR_OFS_CNT: bresp_nxt = `CPR_RESP_OKAY;
        default: bresp_nxt = `CPR_RESP_DECERR;
      endcase
    end
    awready_nxt = !aw_have_nxt && !bvalid_nxt;
    wready_nxt = !w_have_nxt && !bvalid_nxt;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && AXI_RREADY) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
    if (arready_r && AXI_ARVALID) begin
      rvalid_nxt = 1'b1;
      arready_nxt = 1'b0;
      rresp_nxt = `CPR_RESP_OKAY;
      case (AXI_ARADDR)
        `CPR_OFS_CTRL: rdata_nxt = {24'h000000, ctrl_r};
        `CPR_OFS_STAT: rdata_nxt = {26'h0000000, state_r != cpr_pkg::ST_IDLE,
                                    bl_r, loc_r, pmode_r};
        `CPR_OFS_CNT: rdata_nxt = {16'h0000, cnt_r};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = `CPR_RESP_DECERR;
        end
      endcase
    end
  end

  // R8 reset clears the mode at any time
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pmode_r <= 1'b0;
      loc_r <= 2'h0;
      bl_r <= `CPR_BL_FIX8;
      state_r <= cpr_pkg::ST_IDLE;
      lat_r <= 4'h0;
      beat_r <= `CPR_BEAT_FIRST;
      end_r <= `CPR_BEAT_LAST;
      src_pat_r <= 1'b0;
      cnt_r <= 16'h0000;
      rd_req_r <= 1'b0;
      wr_req_r <= 1'b0;
      ap_r <= 1'b0;
      ba_r <= 3'h0;
      addr_r <= '0;
      dq_r <= 16'h0000;
      oe_r <= 2'h0;
      dq_pat_r <= 1'b0;
      dq_beat_r <= `CPR_BEAT_FIRST;
      ctrl_r <= `CPR_CTRL_RST;
      aw_have_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_have_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `CPR_RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `CPR_RESP_OKAY;
    end else begin
      pmode_r <= pmode_nxt;
      loc_r <= loc_nxt;
      bl_r <= bl_nxt;
      state_r <= state_nxt;
      lat_r <= lat_nxt;
      beat_r <= beat_nxt;
      end_r <= end_nxt;
      src_pat_r <= src_pat_nxt;
      cnt_r <= cnt_nxt;
      rd_req_r <= rd_req_nxt;
      wr_req_r <= wr_req_nxt;
      ap_r <= ap_nxt;
      ba_r <= ba_nxt;
      addr_r <= addr_nxt;
      dq_r <= dq_nxt;
      oe_r <= oe_nxt;
      dq_pat_r <= dq_pat_nxt;
      dq_beat_r <= dq_beat_nxt;
      ctrl_r <= ctrl_nxt;
      aw_have_r <= aw_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_have_r <= w_have_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign ARRAY_RD_REQ = rd_req_r;
  assign ARRAY_WR_REQ = wr_req_r;
  assign ARRAY_AP = ap_r;
  assign ARRAY_BA = ba_r;
  assign ARRAY_ADDR = addr_r;
  assign DQ_OUT = dq_r;
  assign DQ_OE = oe_r;
  assign AXI_AWREADY = awready_r;
  assign AXI_WREADY = wready_r;
  assign AXI_BVALID = bvalid_r;
  assign AXI_BRESP = bresp_r;
  assign AXI_ARREADY = arready_r;
  assign AXI_RVALID = rvalid_r;
  assign AXI_RDATA = rdata_r;
  assign AXI_RRESP = rresp_r;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  logic mr3_wr;
  logic idle_rd;
  assign mr3_wr = (cmd == cpr_pkg::CMD_MRS) && (CMD_BA == `CPR_BA_MR3);
  assign idle_rd = (cmd == cpr_pkg::CMD_READ) &&
                   (state_r == cpr_pkg::ST_IDLE);

  // R1 mode entry
  a_mode_entry: assert property ( // R1
    mr3_wr && CMD_ADDR[`CPR_MR3_EN] |=> pmode_r ##1 pmode_r || mr3_wr)
    else $error("pattern mode not entered");
  // R4 location capture
  a_loc_capture: assert property ( // R4
    mr3_wr |=> loc_r == $past(CMD_ADDR[`CPR_MR3_LOC_HI:`CPR_MR3_LOC_LO]))
    else $error("location field not captured");
  // R3 no array access
  a_pat_no_array: assert property ( // R3
    pmode_r && idle_rd |=> !ARRAY_RD_REQ ##[1:16] dq_pat_r)
    else $error("pattern read reached the array");
  // R6 no precharge
  a_rda_no_pre: assert property ( // R6
    pmode_r && cmd == cpr_pkg::CMD_READ && CMD_ADDR[`CPR_A_AP] |=> !ARRAY_AP)
    else $error("precharge issued in pattern mode");
  // R9 normal read
  a_normal_read: assert property ( // R9
    !pmode_r && idle_rd |=> ARRAY_RD_REQ && !src_pat_r)
    else $error("normal read not sent to array");
  // R10 idle lines zero
  a_lane_zero: assert property ( // R10
    DQ_OE[0] && dq_pat_r && !$past(ctrl_r[`CPR_CTRL_COPY]) |->
      DQ_OUT[7:1] == 7'h00)
    else $error("unused data lines not zero");
  // R11 upper lane bit
  a_upper_copy: assert property ( // R11
    DQ_OE[1] && dq_pat_r |-> DQ_OUT[8] == DQ_OUT[0])
    else $error("upper lane differs from lower lane");
  // R20 alternating pattern
  a_pattern_bit: assert property ( // R20
    DQ_OE[0] && dq_pat_r && loc_r == `CPR_LOC_CAL |->
      DQ_OUT[0] == dq_beat_r[0])
    else $error("calibration pattern bit wrong");
  // R15 upper half start
  a_chop_start: assert property ( // R15
    idle_rd && chop && CMD_ADDR[`CPR_A_NIB] |=>
      beat_r == `CPR_BEAT_HALF && end_r == `CPR_BEAT_LAST)
    else $error("chop burst start wrong");
  // R14 burst ends
  a_burst_end: assert property ( // R14
    state_r == cpr_pkg::ST_BURST && beat_r == end_r |=>
      state_r == cpr_pkg::ST_IDLE ##1 !DQ_OE[0] || state_r != cpr_pkg::ST_IDLE)
    else $error("burst did not end on last beat");
  // R17 latency
  a_latency: assert property ( // R17
    state_r == cpr_pkg::ST_WAIT && lat_r <= 4'h1 |=>
      state_r == cpr_pkg::ST_BURST ##1 DQ_OE[0])
    else $error("latency count wrong");

  c_pat_bl8: cover property (pmode_r && idle_rd && !chop);
  c_pat_bc4_hi: cover property (pmode_r && idle_rd && chop &&
                                CMD_ADDR[`CPR_A_NIB]);
  c_array_rd: cover property (!pmode_r && idle_rd);
  c_mode_exit: cover property (pmode_r && mr3_wr && !CMD_ADDR[`CPR_MR3_EN]);

endmodule : cpr_readout

// ### test/cpr_ctrl_model.sv
`timescale 1ns/100ps
module cpr_ctrl_model (
  input wire logic clk,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [15:0] addr
);
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = 3'h0;
    addr = 16'h0000;
  end

  // one command cycle, then deselect with lines toggled
  task automatic issue(input logic [2:0] rcw, input logic [2:0] b,
                       input logic [15:0] a);
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= {1'h0, rcw};
    ba <= b;
    addr <= a;
    @(posedge clk);
    cs_n <= 1'h1;
    ba <= ~b;
    addr <= ~a;
  endtask : issue

  task automatic mrs3(input logic en, input logic [1:0] loc);
    issue(3'h0, 3'h3, {13'h0000, en, loc});
  endtask : mrs3

  task automatic mrs0(input logic [1:0] bl);
    issue(3'h0, 3'h0, {14'h0000, bl});
  endtask : mrs0

  task automatic rd(input logic nib, input logic bc, input logic ap,
                    input logic [2:0] b);
    issue(3'h5, b, {3'h5, bc, 1'h1, ap, 7'h5B, nib, 2'h0});
  endtask : rd

  task automatic wr(input logic [2:0] b);
    issue(3'h4, b, 16'h0404);
  endtask : wr
endmodule : cpr_ctrl_model

// ### test/cpr_readout_tb.sv
`timescale 1ns/100ps
module cpr_readout_tb;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [15:0] ardata = 16'h0000;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic cs_n, ras_n, cas_n, we_n, rd_req, wr_req, ap;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] oe, bresp, rresp, rd_resp;
  logic [2:0] ba, arr_ba;
  logic [15:0] addr, arr_addr, dq;
  logic [31:0] rdata, rd_val;
  int failures = 0;
  int samples_checked = 0;

  always #50 core_clk = ~core_clk;

  cpr_ctrl_model i_cpr_ctrl_model (.clk(core_clk), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));

  cpr_readout #(.ADDR_W(16)) i_cpr_readout (.CORE_CLK(core_clk),
    .RST_N(rst_n), .CMD_CS_N(cs_n), .CMD_RAS_N(ras_n), .CMD_CAS_N(cas_n),
    .CMD_WE_N(we_n), .CMD_BA(ba), .CMD_ADDR(addr), .ARRAY_RDATA(ardata),
    .ARRAY_RD_REQ(rd_req), .ARRAY_WR_REQ(wr_req), .ARRAY_AP(ap),
    .ARRAY_BA(arr_ba), .ARRAY_ADDR(arr_addr), .DQ_OUT(dq), .DQ_OE(oe),
    .AXI_AWVALID(awvalid), .AXI_AWREADY(awready), .AXI_AWADDR(awaddr),
    .AXI_WVALID(wvalid), .AXI_WREADY(wready), .AXI_WDATA(wdata),
    .AXI_WSTRB(wstrb), .AXI_BVALID(bvalid), .AXI_BREADY(bready),
    .AXI_BRESP(bresp), .AXI_ARVALID(arvalid), .AXI_ARREADY(arready),
    .AXI_ARADDR(araddr), .AXI_RVALID(rvalid), .AXI_RREADY(rready),
    .AXI_RDATA(rdata), .AXI_RRESP(rresp));

  task automatic end_sim();
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      chk("wait_bound", 32'h0, 32'h1);
      end_sim();
    end
  endtask : bound

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] resp);
    int n;
    @(posedge core_clk);
    awvalid <= 1'h1;
    awaddr <= a;
    wvalid <= 1'h1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    bready <= 1'h0;
    bound(n, 40);
    chk("bresp", 32'(resp), 32'(bresp));
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a);
    int n;
    @(posedge core_clk);
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rd_val = rdata;
    rd_resp = rresp;
    rready <= 1'h0;
    bound(n, 40);
  endtask : axi_rd

  task automatic reg_is(input logic [3:0] a, input logic [31:0] exp,
                        input logic [1:0] resp);
    axi_rd(a);
    chk("reg_data", exp, rd_val);
    chk("reg_resp", 32'(resp), 32'(rd_resp));
  endtask : reg_is

  // collect one burst; bit k of bits is the value of beat k
  task automatic burst(input int rl, input int nb, input logic [7:0] bits,
                       input logic copy, input logic wide, input logic arr);
    int n;
    int k;
    logic seen;
    logic [7:0] lo;
    logic [15:0] exp;
    logic [15:0] mask;
    n = 0;
    #1;
    seen = rd_req | ap;
    mask = wide ? 16'hFFFF : 16'h00FF;
    while (oe === 2'h0 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
      seen = seen | rd_req | ap;
    end
    bound(n, 40);
    chk("oe_delay", 32'(rl + 1), 32'(n));
    for (k = 0; k < nb; k++) begin
      lo = copy ? {8{bits[k]}} : {7'h00, bits[k]};
      exp = arr ? ardata : {lo, lo};
      chk("dq", 32'(exp & mask), 32'(dq & mask));
      chk("oe", 32'({wide, 1'h1}), 32'(oe));
      @(posedge core_clk);
      #1;
    end
    chk("oe_end", 32'h0, 32'(oe));
    chk("array_req", 32'(arr), 32'(seen));
  endtask : burst

  task automatic wr_is(input logic exp);
    i_cpr_ctrl_model.wr(3'h2);
    #1;
    chk("wr_req", 32'(exp), 32'(wr_req));
  endtask : wr_is

  task automatic t_regs();
    reg_is(4'h0, 32'h00000051, 2'h0);
    reg_is(4'hC, 32'h00000000, 2'h3);
    axi_wr(4'h4, 32'hFFFFFFFF, 4'hF, 2'h0);
    reg_is(4'h4, 32'h00000000, 2'h0);
    axi_wr(4'hC, 32'h00000000, 4'hF, 2'h3);
    axi_wr(4'h0, 32'h000000FF, 4'h0, 2'h0);
    reg_is(4'h0, 32'h00000051, 2'h0);
  endtask : t_regs

  task automatic t_bl8();
    i_cpr_ctrl_model.mrs3(1'h1, 2'h0);
    reg_is(4'h4, 32'h00000001, 2'h0);
    i_cpr_ctrl_model.rd(1'h0, 1'h1, 1'h1, 3'h6);
    burst(5, 8, 8'hAA, 1'h1, 1'h0, 1'h0);
    reg_is(4'h8, 32'h00000001, 2'h0);
    wr_is(1'h0);
  endtask : t_bl8

  task automatic t_loc();
    i_cpr_ctrl_model.mrs3(1'h0, 2'h0);
    i_cpr_ctrl_model.mrs3(1'h1, 2'h1);
    reg_is(4'h4, 32'h00000003, 2'h0);
    i_cpr_ctrl_model.rd(1'h0, 1'h1, 1'h0, 3'h1);
    burst(5, 8, 8'h00, 1'h1, 1'h0, 1'h0);
  endtask : t_loc

  task automatic t_chop();
    i_cpr_ctrl_model.mrs3(1'h0, 2'h0);
    i_cpr_ctrl_model.mrs0(2'h1);
    i_cpr_ctrl_model.mrs3(1'h1, 2'h0);
    reg_is(4'h4, 32'h00000009, 2'h0);
    i_cpr_ctrl_model.rd(1'h1, 1'h0, 1'h0, 3'h0);
    burst(5, 4, 8'h0A, 1'h1, 1'h0, 1'h0);
    i_cpr_ctrl_model.rd(1'h0, 1'h0, 1'h0, 3'h0);
    burst(5, 4, 8'h0A, 1'h1, 1'h0, 1'h0);
    i_cpr_ctrl_model.rd(1'h0, 1'h1, 1'h0, 3'h0);
    burst(5, 8, 8'hAA, 1'h1, 1'h0, 1'h0);
    i_cpr_ctrl_model.mrs3(1'h0, 2'h0);
    i_cpr_ctrl_model.mrs0(2'h2);
    i_cpr_ctrl_model.mrs3(1'h1, 2'h0);
    i_cpr_ctrl_model.rd(1'h1, 1'h1, 1'h0, 3'h4);
    burst(5, 4, 8'h0A, 1'h1, 1'h0, 1'h0);
  endtask : t_chop

  task automatic t_wide();
    axi_wr(4'h0, 32'h00000032, 4'hF, 2'h0);
    reg_is(4'h0, 32'h00000032, 2'h0);
    i_cpr_ctrl_model.rd(1'h1, 1'h1, 1'h0, 3'h7);
    burst(3, 4, 8'h0A, 1'h0, 1'h1, 1'h0);
  endtask : t_wide

  task automatic t_normal();
    i_cpr_ctrl_model.mrs3(1'h0, 2'h3);
    ardata <= 16'hC35A;
    i_cpr_ctrl_model.rd(1'h0, 1'h1, 1'h1, 3'h5);
    burst(3, 4, 8'h00, 1'h0, 1'h1, 1'h1);
    chk("array_ba", 32'h5, 32'(arr_ba));
    chk("array_addr", 32'h0000BED8, 32'(arr_addr));
    wr_is(1'h1);
  endtask : t_normal

  task automatic t_reset();
    i_cpr_ctrl_model.mrs3(1'h1, 2'h0);
    @(posedge core_clk);
    rst_n <= 1'h0;
    @(posedge core_clk);
    rst_n <= 1'h1;
    reg_is(4'h4, 32'h00000000, 2'h0);
    reg_is(4'h0, 32'h00000051, 2'h0);
    reg_is(4'h8, 32'h00000000, 2'h0);
    i_cpr_ctrl_model.rd(1'h0, 1'h1, 1'h0, 3'h2);
    burst(5, 8, 8'h00, 1'h1, 1'h0, 1'h1);
  endtask : t_reset

  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    t_regs();
    t_bl8();
    t_loc();
    t_chop();
    t_wide();
    t_normal();
    t_reset();
    end_sim();
  end
endmodule : cpr_readout_tb
